/* rtl/mits_target.v */
`timescale 1ns/1ps
`include "mits_map.vh"
// Function
// - Acknowledge address and command, load pointer.
// - Two data bytes follow, each acknowledged.
// - Read returns register named by pointer.
// - Send high byte, then low byte.
// - Pointer kept across reads until written.
// - Alerting device answers alert-response with address.
// - Open-drain arbitration, lower address wins.
// - Loser does not acknowledge, keeps alert.
// - Successful alert response releases alert.
// - Address from two four-way select pins.
// - Select pins sampled at every transaction.
// - Alert low from a monitoring event until a successful alert response.
module mits_target (
   clock,
   sys_rst,
   scl_in,
   sda_in,
   sda_out,
   sda_oe_n,
   addr_select_high_pin,
   addr_select_low_pin,
   alert_event,
   reg_rdata,
   reg_ptr,
   reg_wdata,
   reg_wr_stb,
   alert_out,
   alert_oe_n
);
   input wire clock;
   input wire sys_rst;
   input wire scl_in;
   input wire sda_in;
   output reg sda_out;
   output reg sda_oe_n;
   input wire [1:0] addr_select_high_pin;
   input wire [1:0] addr_select_low_pin;
   input wire alert_event;
   input wire [15:0] reg_rdata;
   output reg [7:0] reg_ptr;
   output reg [15:0] reg_wdata;
   output reg reg_wr_stb;
   output reg alert_out;
   output reg alert_oe_n;

   localparam ST_IDLE = 6'h01;
   localparam ST_ADDR = 6'h02;
   localparam ST_WRB = 6'h04;
   localparam ST_ACK = 6'h08;
   localparam ST_RDB = 6'h10;
   localparam ST_RACK = 6'h20;

   wire scl_s;
   wire sda_s;
   mits_sync #(.RESET_VAL(1'b1)) u_scl (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(scl_in),
      .sync_out(scl_s)
   );
   mits_sync #(.RESET_VAL(1'b1)) u_sda (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   // The strap pins come straight from the board, so each bit is synchronised.
   wire [1:0] sel_hi_s;
   wire [1:0] sel_lo_s;
   mits_sync #(.RESET_VAL(1'b0)) u_sel_hi1 (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(addr_select_high_pin[1]),
      .sync_out(sel_hi_s[1])
   );
   mits_sync #(.RESET_VAL(1'b0)) u_sel_hi0 (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(addr_select_high_pin[0]),
      .sync_out(sel_hi_s[0])
   );
   mits_sync #(.RESET_VAL(1'b0)) u_sel_lo1 (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(addr_select_low_pin[1]),
      .sync_out(sel_lo_s[1])
   );
   mits_sync #(.RESET_VAL(1'b0)) u_sel_lo0 (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(addr_select_low_pin[0]),
      .sync_out(sel_lo_s[0])
   );

   reg scl_q;
   reg sda_q;
   reg [5:0] st_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg [1:0] wcnt_q;
   reg rd_lo_q;
   reg ara_q;
   reg lost_q;
   reg [6:0] my_addr_q;
   reg [15:0] rd_q;
   reg alert_pend_q;

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_c = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
   wire [7:0] rx_byte = {sh_q[6:0], sda_s};
   wire [6:0] strap_addr = `MITS_ADDR_BASE | {3'h0, sel_hi_s, sel_lo_s};
   wire [6:0] tx_addr = my_addr_q;

   always @(posedge clock) begin
      if (sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         wcnt_q <= 2'h0;
         rd_lo_q <= 1'b0;
         ara_q <= 1'b0;
         lost_q <= 1'b0;
         my_addr_q <= `MITS_ADDR_BASE;
         rd_q <= 16'h0000;
         alert_pend_q <= 1'b0;
         sda_out <= 1'b1;
         sda_oe_n <= 1'b1;
         reg_ptr <= `MITS_PTR_RESET;
         reg_wdata <= 16'h0000;
         reg_wr_stb <= 1'b0;
         alert_out <= 1'b0;
         alert_oe_n <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         reg_wr_stb <= 1'b0;
         if (start_c) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            wcnt_q <= 2'h0;
            lost_q <= 1'b0;
            my_addr_q <= strap_addr;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            st_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (st_q)
               ST_ADDR, ST_WRB: begin
                  if (scl_rise) begin
                     sh_q <= rx_byte;
                     bit_q <= bit_q + 4'h1;
                  end
                  if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (st_q == ST_ADDR) begin
                        if (sh_q[7:1] == my_addr_q) begin
                           ara_q <= 1'b0;
                           rd_q <= reg_rdata;
                           rd_lo_q <= sh_q[0];
                        end else if (sh_q == {`MITS_ARA_ADDR, 1'b1} && alert_pend_q) begin
                           ara_q <= 1'b1;
                           rd_q <= {my_addr_q, 1'b0, 8'h00};
                           rd_lo_q <= 1'b1;
                        end
                        if ((sh_q[7:1] == my_addr_q) ||
                            (sh_q == {`MITS_ARA_ADDR, 1'b1} && alert_pend_q)) begin
                           sda_oe_n <= 1'b0;
                           sda_out <= 1'b0;
                           st_q <= ST_ACK;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else begin
                        if (wcnt_q == 2'h0) begin
                           reg_ptr <= sh_q;
                        end else if (wcnt_q == 2'h1) begin
                           reg_wdata[15:8] <= sh_q;
                        end else if (wcnt_q == 2'h2) begin
                           reg_wdata[7:0] <= sh_q;
                           reg_wr_stb <= 1'b1;
                        end
                        if (wcnt_q != 2'h3) begin
                           wcnt_q <= wcnt_q + 2'h1;
                        end
                        sda_oe_n <= (wcnt_q == 2'h3);
                        sda_out <= 1'b0;
                        st_q <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rd_lo_q | ara_q) begin
                        st_q <= ST_RDB;
                        rd_lo_q <= 1'b0;
                        sda_out <= rd_q[15];
                        sda_oe_n <= rd_q[15];
                        rd_q <= {rd_q[14:0], 1'b0};
                        bit_q <= 4'h1;
                     end else begin
                        sda_oe_n <= 1'b1;
                        st_q <= ST_WRB;
                     end
                  end
               end
               ST_RDB: begin
                  if (scl_rise && !sda_oe_n == 1'b0 && !sda_s && ara_q && !lost_q) begin
                     lost_q <= 1'b1;
                  end
                  if (scl_fall) begin
                     if (bit_q == 4'h8 || bit_q == 4'h0) begin
                        sda_oe_n <= 1'b1;
                        st_q <= ST_RACK;
                        if (ara_q && !lost_q && !(sda_oe_n && !sda_s)) begin
                           alert_pend_q <= 1'b0;
                        end
                     end else if (lost_q || (ara_q && sda_oe_n && !sda_s)) begin
                        sda_oe_n <= 1'b1;
                        lost_q <= 1'b1;
                        st_q <= ST_IDLE;
                     end else begin
                        sda_out <= rd_q[15];
                        sda_oe_n <= rd_q[15];
                        rd_q <= {rd_q[14:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     if (sda_s || ara_q) begin
                        st_q <= ST_IDLE;
                     end else begin
                        bit_q <= 4'h0;
                     end
                  end
                  if (scl_fall && !ara_q) begin
                     st_q <= ST_RDB;
                     sda_out <= rd_q[15];
                     sda_oe_n <= rd_q[15];
                     rd_q <= {rd_q[14:0], 1'b0};
                     bit_q <= 4'h1;
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
         if (alert_event) begin
            alert_pend_q <= 1'b1;
         end
         alert_out <= 1'b0;
         alert_oe_n <= ~(alert_pend_q | alert_event);
      end
   end
endmodule

/* include/mits_map.vh */
`ifndef MITS_MAP_VH
`define MITS_MAP_VH
`define MITS_ADDR_BASE 7'h40
`define MITS_ARA_ADDR 7'h0c
`define MITS_PTR_RESET 8'h00
`define MITS_SEL_GND 2'h0
`define MITS_SEL_VS 2'h1
`define MITS_SEL_SDA 2'h2
`define MITS_SEL_SCL 2'h3
`endif

/* rtl/mits_sync.v */
`timescale 1ns/1ps
// Two flip-flop synchroniser for one level from outside the clock domain.
module mits_sync (
   clock,
   sys_rst,
   async_in,
   sync_out
);
   parameter RESET_VAL = 1'b1;
   input wire clock;
   input wire sys_rst;
   input wire async_in;
   output wire sync_out;
   reg meta_q;
   reg sync_q;
   always @(posedge clock) begin
      if (sys_rst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule

/* tb/mits_sva.sv */
`timescale 1ns/1ps
module mits_sva (
   input wire clock,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_oe_n,
   input wire alert_event,
   input wire [7:0] reg_ptr,
   input wire reg_wr_stb,
   input wire alert_out,
   input wire alert_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence ack_soon;
      ##[0:8] !sda_oe_n;
   endsequence
   reset_state_a: assert property (
      $fell(sys_rst) |-> sda_oe_n && alert_oe_n && reg_ptr == 8'h00 && !reg_wr_stb)
      else $error("bad state after reset");
   ptr_load_ack_a: assert property (!$stable(reg_ptr) |-> ack_soon)
      else $error("pointer load without ack");
   stb_one_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
      else $error("strobe longer than one cycle");
   stb_with_ack_a: assert property (reg_wr_stb |-> ack_soon)
      else $error("strobe without ack");
   sda_drive_low_a: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2))
      else $error("data drive starts outside clock low");
   alert_drive_a: assert property (alert_event |-> ##[1:2] !alert_oe_n)
      else $error("alert not driven");
   alert_level_a: assert property (!alert_out)
      else $error("alert level not low");
   alert_release_a: assert property ($rose(alert_oe_n) |-> !$past(alert_event))
      else $error("alert released during event");
endmodule
bind mits_target mits_sva chk (.*);

/* tb/mits_host.sv */
`timescale 1ns/1ps
// Bus controller: drives the clock and pulls the data line low when sda_lo is set.
module mits_host (
   output logic scl,
   output logic sda_lo,
   input wire sda
);
   initial begin
      scl = 1'b1;
      sda_lo = 1'b0;
   end
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_lo = !tx[i];
         #40 scl = 1'b1;
         #78 rx[i] = sda;
         #2 scl = 1'b0;
      end
   endtask
   task automatic start;
      #40 sda_lo = 1'b0;
      #40 scl = 1'b1;
      #80 sda_lo = 1'b1;
      #80 scl = 1'b0;
   endtask
   task automatic stop;
      #40 sda_lo = 1'b1;
      #40 scl = 1'b1;
      #80 sda_lo = 1'b0;
      #80;
   endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] sel_hi = 2'h0;
   logic [1:0] sel_lo = 2'h0;
   logic alert_event = 1'b0;
   logic [8:0] rx;
   int miscompares = 0;
   int n_compared = 0;
   int stb_n = 0;
   wire scl, sda_lo, sda_out, sda_oe_n, reg_wr_stb, alert_oe_n;
   wire [7:0] reg_ptr;
   wire [15:0] reg_wdata;
   wire sda = !sda_lo && (sda_oe_n || sda_out);
   always #10 clock = ~clock;
   always @(posedge clock) stb_n <= stb_n + reg_wr_stb;
   mits_host host (.scl(scl), .sda_lo(sda_lo), .sda(sda));
   mits_target uut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_high_pin(sel_hi),
      .addr_select_low_pin(sel_lo), .alert_event(alert_event),
      .reg_rdata({reg_ptr ^ 8'ha5, reg_ptr}), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
      .reg_wr_stb(reg_wr_stb), .alert_out(), .alert_oe_n(alert_oe_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d, input logic ack);
      host.xfer({d, 1'b1}, rx);
      chk(rx[0], ack);
   endtask
   task automatic rd(input logic last, input logic [7:0] exp);
      host.xfer({8'hff, last}, rx);
      chk(rx[8:1], exp);
   endtask
   task automatic t_write;
      host.start();
      wr(8'h80, 1'b0);
      wr(8'h03, 1'b0);
      wr(8'h12, 1'b0);
      wr(8'h34, 1'b0);
      wr(8'h56, 1'b1);
      host.stop();
      chk(reg_ptr, 8'h03);
      chk(reg_wdata, 16'h1234);
      chk(16'(stb_n), 16'h1);
   endtask
   task automatic t_read;
      for (int k = 0; k < 2; k++) begin
         host.start();
         wr(8'h81, 1'b0);
         rd(1'b0, 8'ha6);
         rd(1'b1, 8'h03);
         host.stop();
      end
      sel_hi = 2'h2;
      sel_lo = 2'h3;
      host.start();
      wr(8'h80, 1'b1);
      host.stop();
      host.start();
      wr(8'h96, 1'b0);
      wr(8'h07, 1'b0);
      host.start();
      wr(8'h97, 1'b0);
      rd(1'b0, 8'ha2);
      rd(1'b1, 8'h07);
      host.stop();
   endtask
   task automatic t_alert;
      host.start();
      wr(8'h19, 1'b1);
      host.stop();
      chk(alert_oe_n, 1'b1);
      alert_event = 1'b1;
      #20 alert_event = 1'b0;
      #40 chk(alert_oe_n, 1'b0);
      host.start();
      wr(8'h19, 1'b0);
      host.xfer(9'h080, rx);
      chk(rx[8:1], 8'h40);
      host.stop();
      chk(alert_oe_n, 1'b0);
      host.start();
      wr(8'h19, 1'b0);
      rd(1'b1, 8'h96);
      host.stop();
      chk(alert_oe_n, 1'b1);
   endtask
   task automatic end_sim;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      t_write;
      t_read;
      t_alert;
      end_sim;
   end
   initial begin
      #400000;
      miscompares++;
      end_sim;
   end
endmodule
